// file: logic/coprocessor_divide_unit.sv
// Purpose: division path of the arithmetic coprocessor attached to the 16-bit core
// Assumes: one instruction strobe at a time; the core waits for result_valid
// Notes:   multiply and accumulate modes are not served here
`timescale 1ns/10ps
`default_nettype none
module coprocessor_divide_unit (
    input  wire logic                                clock,
    input  wire logic                                rst,
    input  wire logic                                mode_write_instr,
    input  wire logic [7:0]                          mode_word,
    input  wire logic                                operand_preload_instr,
    input  wire logic                                compute_return_instr,
    input  wire logic [copro_div_pkg::HALF_W-1:0]    operand_first,
    input  wire logic [copro_div_pkg::HALF_W-1:0]    operand_second,
    input  wire logic                                use_short_immediate,
    input  wire logic [copro_div_pkg::HALF_W-1:0]    short_immediate,
    output logic                                     busy,
    output logic                                     result_valid,
    output logic      [copro_div_pkg::HALF_W-1:0]    result_half,
    output logic      [copro_div_pkg::FLAG_W-1:0]    arith_flag_set,
    output logic      [7:0]                          mode
);
    import copro_div_pkg::*;

    logic [DATA_W-1:0] result_reg_zero, next_result_reg_zero;
    logic [DATA_W-1:0] result_reg_one, next_result_reg_one;
    logic [7:0]        next_mode;
    div_state_e        state, next_state;
    logic              next_busy, next_result_valid;
    logic [HALF_W-1:0] next_result_half;
    logic [FLAG_W-1:0] next_arith_flag_set;
    logic              neg_quo, next_neg_quo, neg_rem, next_neg_rem;
    logic [3:0]        sel_half, next_sel_half;

    logic              div_start;
    logic [DATA_W-1:0] div_dividend, div_divisor, div_quo, div_rem;
    logic              div_done;
    logic [DATA_W-1:0] divisor_full, fixed_quo, fixed_rem;
    logic [HALF_W-1:0] second_half;
    logic              signed_div;

    restoring_divider #(.WIDTH(DATA_W)) u_div (
        .clock     (clock),
        .rst       (rst),
        .start     (div_start),
        .dividend  (div_dividend),
        .divisor   (div_divisor),
        .done      (div_done),
        .quotient  (div_quo),
        .remainder (div_rem)
    );

    // pick a half of the result registers by selector
    function automatic logic [HALF_W-1:0] pick_half(input logic [3:0] sel,
                                                     input logic [DATA_W-1:0] r0,
                                                     input logic [DATA_W-1:0] r1);
        logic [HALF_W-1:0] h;
        h = r0[HALF_W-1:0];
        unique case (sel)
            SEL_RESULT_REG_ZERO_HI: h = r0[DATA_W-1:HALF_W];
            SEL_RESULT_REG_ONE_LO: h = r1[HALF_W-1:0];
            SEL_RESULT_REG_ONE_HI: h = r1[DATA_W-1:HALF_W];
            default:     h = r0[HALF_W-1:0];                       // SEL_RESULT_REG_ZERO_LO and reserved selectors
        endcase
        return h;
    endfunction : pick_half

    always_comb begin
        second_half  = use_short_immediate ? short_immediate : operand_second;
        divisor_full = {operand_first, second_half};
        signed_div   = (mode[3:0] == OP_DIVS);
        // signed division runs on magnitudes, signs are restored afterwards
        div_dividend = (signed_div && result_reg_zero[DATA_W-1]) ? -result_reg_zero
                                                                  : result_reg_zero;
        div_divisor  = (signed_div && divisor_full[DATA_W-1]) ? -divisor_full : divisor_full;
        fixed_quo    = neg_quo ? -div_quo : div_quo;
        fixed_rem    = neg_rem ? -div_rem : div_rem;
        div_start    = 1'b0;

        next_state           = state;
        next_mode            = mode;
        next_result_reg_zero = result_reg_zero;
        next_result_reg_one  = result_reg_one;
        next_busy            = busy;
        next_result_valid    = 1'b0;
        next_result_half     = result_half;
        next_arith_flag_set  = arith_flag_set;
        next_neg_quo         = neg_quo;
        next_neg_rem         = neg_rem;
        next_sel_half        = sel_half;

        unique case (state)
            ST_IDLE: begin
                if (mode_write_instr) begin
                    next_mode = mode_word;
                    if (mode_word[3:0] == OP_INIT0) begin
                        next_result_reg_zero = RES_RESET;
                        next_result_reg_one  = RES_RESET;
                    end
                end else if (operand_preload_instr) begin
                    unique case (mode[3:0])
                        OP_INIT1: next_result_reg_zero = {{HALF_W{1'b0}}, second_half};
                        OP_INIT2: next_result_reg_zero = {operand_first, second_half};
                        OP_INIT3: next_result_reg_one  = {operand_first, second_half};
                        default: ;
                    endcase
                end else if (compute_return_instr) begin
                    if (mode[3:0] == OP_DIVU || mode[3:0] == OP_DIVS) begin
                        // hold the core off while the iteration runs
                        div_start     = 1'b1;
                        next_busy     = 1'b1;
                        next_neg_quo  = signed_div &
                                        (result_reg_zero[DATA_W-1] ^ divisor_full[DATA_W-1]);
                        next_neg_rem  = signed_div & result_reg_zero[DATA_W-1];
                        next_sel_half = mode[7:4];
                        next_state    = ST_DIV;
                    end else if (mode[3:0] == OP_READ) begin
                        // registers stay untouched in read mode
                        next_result_half  = pick_half(mode[7:4], result_reg_zero,
                                                      result_reg_one);
                        next_result_valid = 1'b1;
                    end else begin
                        next_result_half  = pick_half(mode[7:4], result_reg_zero,
                                                      result_reg_one);
                        next_result_valid = 1'b1;
                    end
                end
            end
            ST_DIV: begin
                if (div_done) begin
                    next_state = ST_FIX;
                end
            end
            ST_FIX: begin
                // quotient, remainder and the chosen half all land in the same cycle
                next_result_reg_zero = fixed_quo;
                next_result_reg_one  = fixed_rem;
                next_result_half     = pick_half(sel_half, fixed_quo, fixed_rem);
                next_arith_flag_set  = FLAGS_CLEAR;
                next_result_valid    = 1'b1;
                next_busy            = 1'b0;
                next_state           = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state           <= ST_IDLE;
            mode            <= MODE_RESET;
            result_reg_zero <= RES_RESET;
            result_reg_one  <= RES_RESET;
            busy            <= 1'b0;
            result_valid    <= 1'b0;
            result_half     <= '0;
            arith_flag_set  <= FLAGS_CLEAR;
            neg_quo         <= 1'b0;
            neg_rem         <= 1'b0;
            sel_half        <= SEL_RESULT_REG_ZERO_LO;
        end else begin
            state           <= next_state;
            mode            <= next_mode;
            result_reg_zero <= next_result_reg_zero;
            result_reg_one  <= next_result_reg_one;
            busy            <= next_busy;
            result_valid    <= next_result_valid;
            result_half     <= next_result_half;
            arith_flag_set  <= next_arith_flag_set;
            neg_quo         <= next_neg_quo;
            neg_rem         <= next_neg_rem;
            sel_half        <= next_sel_half;
        end
    end
endmodule : coprocessor_divide_unit
`default_nettype wire

// file: logic/copro_div_pkg.sv
// Purpose: shared constants for the coprocessor divide unit
// Assumes: 16-bit core interface, 32-bit result registers
// Notes:   mode word low nibble is the operation, high nibble the output half
`default_nettype none
package copro_div_pkg;
    localparam int          DATA_W         = 32;
    localparam int          HALF_W         = 16;
    localparam int          FLAG_W         = 4;
    localparam logic [3:0]  OP_INIT0       = 4'h0;
    localparam logic [3:0]  OP_INIT1       = 4'h1;
    localparam logic [3:0]  OP_INIT2       = 4'h2;
    localparam logic [3:0]  OP_READ        = 4'h3;
    localparam logic [3:0]  OP_DIVU        = 4'h8;
    localparam logic [3:0]  OP_DIVS        = 4'h9;
    localparam logic [3:0]  OP_INIT3       = 4'ha;
    localparam logic [3:0]  SEL_RESULT_REG_ZERO_LO    = 4'h0;
    localparam logic [3:0]  SEL_RESULT_REG_ZERO_HI    = 4'h1;
    localparam logic [3:0]  SEL_RESULT_REG_ONE_LO    = 4'h2;
    localparam logic [3:0]  SEL_RESULT_REG_ONE_HI    = 4'h3;
    localparam logic [7:0]  MODE_RESET     = 8'h00;
    localparam logic [31:0] RES_RESET      = 32'h0000_0000;
    localparam logic [3:0]  FLAGS_CLEAR    = 4'h0;
    localparam logic [5:0]  DIV_STEPS      = 6'h20;
    typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_FIX} div_state_e;
endpackage : copro_div_pkg
`default_nettype wire

// file: logic/restoring_divider.sv
// Purpose: iterative unsigned restoring divider, one quotient bit per clock
// Assumes: start is a one-cycle pulse while idle
// Notes:   divisor zero gives all-ones quotient and the dividend as remainder
`timescale 1ns/10ps
`default_nettype none
module restoring_divider #(
    parameter int WIDTH = 32
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] dividend,
    input  wire logic [WIDTH-1:0] divisor,
    output logic                  done,
    output logic      [WIDTH-1:0] quotient,
    output logic      [WIDTH-1:0] remainder
);
    // the step counter is six bits wide, so wider operands cannot be counted
    generate
        if (WIDTH < 2 || WIDTH > 63) begin : g_width_check
            $error("restoring_divider: WIDTH out of range");
        end
    endgenerate

    logic [WIDTH-1:0] rem, next_rem, quo, next_quo, dsr, next_dsr;
    logic [5:0]       cnt, next_cnt;
    logic             busy, next_busy, next_done;
    logic [WIDTH:0]   trial;

    always_comb begin
        next_rem  = rem;
        next_quo  = quo;
        next_dsr  = dsr;
        next_cnt  = cnt;
        next_busy = busy;
        next_done = 1'b0;
        trial     = '0;
        if (start && !busy) begin
            next_rem  = '0;
            next_quo  = dividend;
            next_dsr  = divisor;
            next_cnt  = 6'(WIDTH);
            next_busy = 1'b1;
        end else if (busy) begin
            // shift one dividend bit in, subtract if it fits
            trial    = {rem, quo[WIDTH-1]} - {1'b0, dsr};
            next_quo = {quo[WIDTH-2:0], ~trial[WIDTH]};
            next_rem = trial[WIDTH] ? {rem[WIDTH-2:0], quo[WIDTH-1]} : trial[WIDTH-1:0];
            next_cnt = cnt - 6'h01;
            if (cnt == 6'h01) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rem  <= '0;
            quo  <= '0;
            dsr  <= '0;
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            rem  <= next_rem;
            quo  <= next_quo;
            dsr  <= next_dsr;
            cnt  <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign quotient  = quo;
    assign remainder = rem;
endmodule : restoring_divider
`default_nettype wire

// file: testbench/copro_div_properties.sv
// Purpose: port-level assertions for the divide unit
// Assumes: single clock domain, synchronous active-high reset
// Notes:   taken means a compute strobe with no higher-priority strobe while idle
`timescale 1ns/10ps
`default_nettype none
module copro_div_properties import copro_div_pkg::*; (
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        mode_write_instr,
    input wire logic [7:0]  mode_word,
    input wire logic        operand_preload_instr,
    input wire logic        compute_return_instr,
    input wire logic        busy,
    input wire logic        result_valid,
    input wire logic [15:0] result_half,
    input wire logic [3:0]  arith_flag_set,
    input wire logic [7:0]  mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic take;
    logic dv;
    assign take = compute_return_instr && !busy && !mode_write_instr && !operand_preload_instr;
    assign dv = mode[3:0] == OP_DIVU || mode[3:0] == OP_DIVS;
    AST_DIV_LAT: assert property (take && dv |-> ##35 (result_valid && !busy))
        else $error("division answer not on cycle 35");
    AST_DIV_BUSY: assert property (take && dv |=> busy [*8])
        else $error("busy not held during division");
    AST_DIV_QUIET: assert property (take && dv |=> !result_valid [*8])
        else $error("answer before division finished");
    AST_READ_LAT: assert property (take && mode[3:0] == OP_READ |=> result_valid)
        else $error("read answer missing");
    AST_FLAGS: assert property (result_valid && dv |-> arith_flag_set == FLAGS_CLEAR)
        else $error("flags not cleared by division");
    AST_MODE_WR: assert property (mode_write_instr && !busy |=> mode == $past(mode_word))
        else $error("mode word not stored");
    AST_REFUSE: assert property (busy && mode_write_instr |=> mode == $past(mode))
        else $error("mode changed while busy");
    AST_HALF_HOLD: assert property (!result_valid |-> $stable(result_half))
        else $error("returned half changed without an answer");
    COV_DIV: cover property (take && dv);
    COV_READ: cover property (take && mode[3:0] == OP_READ);
    COV_REFUSE: cover property (busy && mode_write_instr);
endmodule : copro_div_properties
bind coprocessor_divide_unit copro_div_properties chk (.clock, .rst, .mode_write_instr,
    .mode_word, .operand_preload_instr, .compute_return_instr, .busy, .result_valid,
    .result_half, .arith_flag_set, .mode);
`default_nettype wire

// file: testbench/core_model.sv
// Purpose: model of the 16-bit core issuing coprocessor instructions
// Assumes: one strobe per call, driven at the falling edge
// Notes:   idle operand lines show the inverse of the last value, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module core_model (
    input  wire logic        clock,
    input  wire logic        result_valid,
    output logic             mode_write_instr,
    output logic [7:0]       mode_word,
    output logic             operand_preload_instr,
    output logic             compute_return_instr,
    output logic [15:0]      operand_first,
    output logic [15:0]      operand_second,
    output logic             use_short_immediate,
    output logic [15:0]      short_immediate
);
    initial begin
        {mode_write_instr, operand_preload_instr, compute_return_instr} = 3'h0;
        {mode_word, operand_first, operand_second, short_immediate} = 56'h0;
        use_short_immediate = 1'b0;
    end
    // kind 0 mode write, 1 preload, 2 compute; im routes b through the immediate
    task send(input logic [1:0] k, input logic [7:0] w, input logic [15:0] a, b,
              input logic im);
        @(negedge clock);
        mode_write_instr = k == 2'd0;
        operand_preload_instr = k == 2'd1;
        compute_return_instr = k == 2'd2;
        mode_word = w;
        operand_first = a;
        use_short_immediate = im;
        operand_second = im ? ~b : b;
        short_immediate = im ? b : ~b;
        @(negedge clock);
        {mode_write_instr, operand_preload_instr, compute_return_instr} = 3'h0;
        {mode_word, operand_first, operand_second} = ~{w, a, operand_second};
        short_immediate = ~short_immediate;
    endtask : send
    // the core holds off until the answer strobe, bounded so a hang cannot stall it
    task wait_valid;
        for (int n = 0; n < 40 && result_valid !== 1'b1; n++) @(negedge clock);
    endtask : wait_valid
endmodule : core_model
`default_nettype wire

// file: testbench/coprocessor_divide_unit_bench.sv
// Purpose: self-checking bench for the coprocessor divide unit
// Assumes: core model drives strobes; expectations queued in issue order
// Notes:   divisor never zero, so the unsupported zero case is never hit
`timescale 1ns/10ps
`default_nettype none
module coprocessor_divide_unit_bench;
    import copro_div_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        mode_write_instr, operand_preload_instr, compute_return_instr;
    logic        use_short_immediate, busy, result_valid;
    logic [7:0]  mode_word, mode;
    logic [15:0] operand_first, operand_second, short_immediate, result_half;
    logic [3:0]  arith_flag_set;
    integer      seed = 32'h897f96db;
    int          bad_count = 0;
    int          checks = 0;
    logic [15:0] q[$];
    always #2.5 clock = ~clock;
    core_model core (.clock, .result_valid, .mode_write_instr, .mode_word,
        .operand_preload_instr, .compute_return_instr, .operand_first,
        .operand_second, .use_short_immediate, .short_immediate);
    coprocessor_divide_unit uut (.clock, .rst, .mode_write_instr, .mode_word,
        .operand_preload_instr, .compute_return_instr, .operand_first,
        .operand_second, .use_short_immediate, .short_immediate, .busy,
        .result_valid, .result_half, .arith_flag_set, .mode);
    task cmp_half(input logic [15:0] got, exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t half got %h exp %h", $time, got, exp);
        end
    endtask : cmp_half
    task cmp_flags(input logic [3:0] got, exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t flags got %h exp %h", $time, got, exp);
        end
    endtask : cmp_flags
    task test_done;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    always @(negedge clock) begin
        if (result_valid === 1'b1) begin
            cmp_flags(arith_flag_set, 4'h0);
            cmp_half(result_half, q.size() ? q.pop_front() : ~result_half);
        end
    end
    task rd(input logic [7:0] w, input logic [15:0] e);
        q.push_back(e);
        core.send(2'd0, w, 16'h0, 16'h0, 1'b0);
        core.send(2'd2, 8'h00, 16'($random(seed)), 16'($random(seed)), 1'b0);
        core.wait_valid;
    endtask : rd
    initial begin
        #24000;
        bad_count++;
        test_done;
    end
    initial begin
        logic [31:0] a, b, qt, rm;
        logic [15:0] h [4];
        logic [3:0]  op, sel;
        logic        im;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        rd(8'h23, 16'h0000);
        for (int i = 0; i < 40; i++) begin
            a = $random(seed);
            b = $random(seed) & (i[0] ? 32'hffffffff : 32'h0000ffff);
            if (b == 32'h0) b = 32'h3;
            op = i[1] ? OP_DIVS : OP_DIVU;
            sel = 4'((i >> 2) % 4);
            im = i[3];
            // kept apart: a ternary with one unsigned arm would make the signed arm unsigned
            if (op == OP_DIVS) begin
                qt = $signed(a) / $signed(b);
                rm = $signed(a) % $signed(b);
            end else begin
                qt = a / b;
                rm = a % b;
            end
            h = '{qt[15:0], qt[31:16], rm[15:0], rm[31:16]};
            core.send(2'd0, 8'h02, a[15:0], a[31:16], 1'b0);
            core.send(2'd1, 8'h55, a[31:16], a[15:0], im);
            core.send(2'd0, {sel, op}, a[15:0], a[31:16], 1'b0);
            q.push_back(h[sel]);
            core.send(2'd2, 8'h00, b[31:16], b[15:0], ~im);
            if (i == 0) core.send(2'd0, 8'h13, 16'h0, 16'h0, 1'b0);
            core.wait_valid;
            for (int s = 0; s < 5; s++) rd({4'(s), OP_READ}, h[s % 4]);
        end
        // the 16-bit and register-one preload modes, read back without computing
        core.send(2'd0, 8'h01, 16'h0, 16'h0, 1'b0);
        core.send(2'd1, 8'h00, a[31:16], a[15:0], 1'b0);
        core.send(2'd0, 8'h0a, 16'h0, 16'h0, 1'b0);
        core.send(2'd1, 8'h00, b[31:16], b[15:0], 1'b1);
        rd(8'h13, 16'h0000);
        rd(8'h03, a[15:0]);
        rd(8'h33, b[31:16]);
        core.send(2'd0, 8'h00, 16'h0, 16'h0, 1'b0);
        rd(8'h33, 16'h0000);
        // let the monitor take the last answer before the queue is looked at
        @(negedge clock);
        cmp_half(16'(q.size()), 16'h0000);
        test_done;
    end
endmodule : coprocessor_divide_unit_bench
`default_nettype wire
